// >>> flash_ctrl_status.sv
/*
  APB register bank for flash control and status, with command gate
  and a masked interrupt.
  Assumes an APB master on mclk, a sequencer giving one-cycle events,
  and protect and mask ROM levels synchronous to mclk.
*/
// Local design decision: register access over APB.
`include "flash_csr_cfg.svh"

module flash_ctrl_status #(
  parameter int ADDR_W = 32,
  parameter int AREAS = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire flash_csr_pkg::seq_evt_t seq_evt,
  input wire logic [AREAS-1:0] area_protect,
  input wire logic mask_rom_strap,
  input wire flash_csr_pkg::cmd_req_t cmd,
  output flash_csr_pkg::cmd_req_t cmd_fwd,
  output logic cmd_refuse,
  output logic cmd_issue_flag,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Field layout fixes four areas and full 32-bit addresses
  if (AREAS != 4) begin : g_bad_areas
    $error("AREAS must be 4");
  end
  if (ADDR_W != 32) begin : g_bad_addr
    $error("ADDR_W must be 32");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ready; // Sequencer can take a command
  logic busy; // Automatic operation running
  logic issue_reg; // Command issue flag
  logic rom_kind_reg; // Captured mask ROM strap
  logic strap_taken_reg; // Strap capture done
  logic [AREAS-1:0] prot_reg; // Registered protect flags
  logic jam_reg; // Commands locked out after collision
  logic [`EV_W-1:0] irq_stat_reg; // Sticky events
  logic [`EV_W-1:0] irq_stat_next;
  logic [`EV_W-1:0] irq_mask_reg; // Event enables
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  flash_csr_pkg::cmd_req_t cmd_fwd_reg;
  logic cmd_refuse_reg;
  logic setup; // APB setup cycle
  logic wr_commit; // Write takes effect
  logic secure; // All areas protected
  logic area_locked; // Write aims at protected area
  logic cmd_ok; // Command passes the gate
  logic collide; // Command while busy
  logic [`EV_W-1:0] events; // Raw event pulses

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // True when the address names one of the three registers
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == `CSR_STATUS_ADDR) || (a == `CSR_IRQ_STAT_ADDR) ||
                (a == `CSR_IRQ_MASK_ADDR);
  endfunction

  // Status word; reserved bits pinned to zero
  function automatic logic [31:0] status_word(input logic rdy, input logic iss,
                                              input logic rk, input logic [3:0] pr);
    logic [31:0] w;
    w = 32'h00000000;
    w[`READY_BIT] = rdy;
    w[`ISSUE_BIT] = iss;
    w[`ROMK_BIT] = rk;
    w[`PROT_MSB:`PROT_LSB] = pr;
    status_word = w;
  endfunction

  assign setup = psel && !penable;
  assign wr_commit = psel && penable && pready_reg && pwrite && is_mapped(paddr);

  // ----------------------------------------------------------------
  // Sequencer tracking
  // ----------------------------------------------------------------
  ready_tracker u_tracker (
    .mclk(mclk),
    .reset(reset),
    .evt(seq_evt),
    .reset_cmd(cmd_ok && cmd.is_reset),
    .ready(ready),
    .busy(busy)
  );

  // ----------------------------------------------------------------
  // Command gate
  // ----------------------------------------------------------------
  // Each area checked on its own, any mix may be set
  assign area_locked = cmd.is_write && prot_reg[cmd.area];
  assign secure = (prot_reg == `SECURE_CODE);
  assign collide = cmd.valid && !cmd.is_reset && busy;
  // Reset command bypasses ready and jam, never the secure lock
  assign cmd_ok = cmd.valid && !secure &&
                  (cmd.is_reset || (ready && !jam_reg && !area_locked));

  // Forward or refuse, one-cycle pulse either way
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_fwd_reg <= '0;
      cmd_refuse_reg <= 1'b0;
    end else begin
      cmd_fwd_reg <= cmd_ok ? cmd : '0;
      cmd_refuse_reg <= cmd.valid && !cmd_ok;
    end
  end

  // Collision lock; cleared by an accepted reset command
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      jam_reg <= 1'b0;
    end else if (collide) begin
      jam_reg <= 1'b1;
    end else if (cmd_ok && cmd.is_reset) begin
      jam_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status inputs
  // ----------------------------------------------------------------
  // Protect flags follow the sequencer, one cycle late
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prot_reg <= '0;
    end else begin
      prot_reg <= area_protect;
    end
  end

  // Strap caught once after release; reset must not sample a port
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rom_kind_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      rom_kind_reg <= mask_rom_strap;
      strap_taken_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Only bit 1 of status is writable; others ignored
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      issue_reg <= 1'b0;
    end else if (wr_commit && paddr == `CSR_STATUS_ADDR) begin
      issue_reg <= pwdata[`ISSUE_BIT];
    end
  end

  // Mask register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_mask_reg <= `IRQ_RST;
    end else if (wr_commit && paddr == `CSR_IRQ_MASK_ADDR) begin
      irq_mask_reg <= pwdata[`EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[`EV_DONE] = seq_evt.done && busy;
    events[`EV_FAIL] = seq_evt.fail && busy;
    events[`EV_COLLIDE] = collide;
    events[`EV_REFUSE] = cmd.valid && !cmd_ok;
    irq_stat_next = irq_stat_reg;
    if (wr_commit && paddr == `CSR_IRQ_STAT_ADDR) begin
      irq_stat_next = irq_stat_next & ~pwdata[`EV_W-1:0];
    end
    // Set after clear so an event in the clearing cycle survives
    irq_stat_next = irq_stat_next | events;
  end

  // Sticky bits and level interrupt
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_stat_reg <= `IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // APB read and handshake
  // ----------------------------------------------------------------
  // Answer prepared in setup, so every access has no wait state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !is_mapped(paddr);
      prdata_reg <= 32'h00000000;
      if (!pwrite) begin
        unique case (paddr)
          `CSR_STATUS_ADDR: begin
            prdata_reg <= status_word(ready, issue_reg, rom_kind_reg, prot_reg);
          end
          `CSR_IRQ_STAT_ADDR: begin
            prdata_reg <= {28'h0000000, irq_stat_reg};
          end
          `CSR_IRQ_MASK_ADDR: begin
            prdata_reg <= {28'h0000000, irq_mask_reg};
          end
          default: begin
            prdata_reg <= 32'h00000000; // Unmapped reads zero
          end
        endcase
      end
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign cmd_fwd = cmd_fwd_reg;
  assign cmd_refuse = cmd_refuse_reg;
  // Flag reaches the flash interface; software owns it
  assign cmd_issue_flag = issue_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_status_read;
    psel && !penable && !pwrite && paddr == `CSR_STATUS_ADDR;
  endsequence

  sequence s_op_start;
    ready && seq_evt.start;
  endsequence

  property p_busy_reads_zero;
    s_status_read ##0 busy |=> pready && !prdata[`READY_BIT];
  endproperty
  a_busy_reads_zero: assert property (p_busy_reads_zero)
    else $error("ready bit not 0 while busy");

  property p_done_ready;
    busy && seq_evt.done && !seq_evt.fail |=> ready && !busy;
  endproperty
  a_done_ready: assert property (p_done_ready)
    else $error("ready not back after done");

  property p_fail_holds;
    (busy && seq_evt.fail) ##1 !(cmd.valid && cmd.is_reset)[*3] |-> !ready;
  endproperty
  a_fail_holds: assert property (p_fail_holds)
    else $error("ready rose after failure");

  property p_reset_values;
    $fell(reset) |-> ready && !issue_reg && !rom_kind_reg && prot_reg == '0 && !irq;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong reset values");

  property p_jam;
    jam_reg && cmd.valid && !cmd.is_reset |=> cmd_refuse && !cmd_fwd.valid;
  endproperty
  a_jam: assert property (p_jam)
    else $error("command passed after collision");

  property p_issue_write;
    wr_commit && paddr == `CSR_STATUS_ADDR |=> issue_reg == $past(pwdata[`ISSUE_BIT]);
  endproperty
  a_issue_write: assert property (p_issue_write)
    else $error("issue flag not written");

  // Strap may be caught on the setup edge itself, so compare the old value
  property p_rom_kind;
    s_status_read |=> prdata[`ROMK_BIT] == $past(rom_kind_reg);
  endproperty
  a_rom_kind: assert property (p_rom_kind)
    else $error("rom kind bit wrong");

  property p_prot_read;
    s_status_read |=> prdata[`PROT_MSB:`PROT_LSB] == $past(prot_reg);
  endproperty
  a_prot_read: assert property (p_prot_read)
    else $error("protect bits wrong");

  property p_area_refuse;
    cmd.valid && cmd.is_write && !cmd.is_reset && prot_reg[cmd.area] |=> cmd_refuse && !cmd_fwd.valid;
  endproperty
  a_area_refuse: assert property (p_area_refuse)
    else $error("write into protected area passed");

  property p_secure;
    cmd.valid && prot_reg == `SECURE_CODE |=> cmd_refuse ##0 !cmd_fwd.valid;
  endproperty
  a_secure: assert property (p_secure)
    else $error("command passed in secure state");

  property p_reserved_zero;
    s_status_read |=> prdata[31:8] == 24'h000000 && !prdata[3];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  property p_irq_level;
    ##1 irq == |($past(irq_stat_next) & $past(irq_mask_reg));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq does not follow masked status");

  // Start from ready drops the flag on the next edge
  property p_start_busy;
    s_op_start |=> busy && !ready;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("ready bit not cleared on start");

  // Accepted reset command frees stuck and jam when not running
  property p_reset_cmd_frees;
    cmd_ok && cmd.is_reset && !busy && !seq_evt.start |=> ready && !jam_reg;
  endproperty
  a_reset_cmd_frees: assert property (p_reset_cmd_frees)
    else $error("reset command did not restore ready");

endmodule

// >>> flash_csr_cfg.svh
/*
  Offsets, field positions and reset values of the flash control and
  status register bank, with its interrupt registers.
  Assumes it is included by bare name wherever these constants are used.
*/
// How it works
// - Ready flag reads 0 while sequencer busy
// - Successful finish returns ready flag to 1
// - Failed operation keeps ready flag at 0
// - Reset: ready reads 1, all else 0
// - Command while busy jams further commands
// - Read-write command issue flag at bit 1
// - Bit 2 reads 0 flash, 1 mask ROM
// - Bits 7:4 report four area protect states
// - Writes into protected area are refused
// - Protect flags independent, any combination allowed
// - All four protected: refuse every command
`ifndef FLASH_CSR_CFG_SVH
`define FLASH_CSR_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CSR_STATUS_ADDR 32'hFFFFE520
`define CSR_IRQ_STAT_ADDR 32'hFFFFE524
`define CSR_IRQ_MASK_ADDR 32'hFFFFE528

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define READY_BIT 0
`define ISSUE_BIT 1
`define ROMK_BIT 2
`define PROT_LSB 4
`define PROT_MSB 7
`define STATUS_RST 32'h00000001
`define SECURE_CODE 4'hF

// ----------------------------------------------------------------
// Interrupt event bits and reset values
// ----------------------------------------------------------------
`define EV_DONE 0
`define EV_FAIL 1
`define EV_COLLIDE 2
`define EV_REFUSE 3
`define EV_W 4
`define IRQ_RST 4'h0

`endif

// >>> flash_csr_pkg.sv
/*
  Types shared by the flash control and status register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_csr_pkg;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Command from the CPU side toward the flash interface
  typedef struct packed {
    logic valid;    // One-cycle strobe
    logic is_reset; // Reset command
    logic is_write; // Programs or erases data
    logic [1:0] area; // Target protection area
  } cmd_req_t;

  // Sequencer events, each a one-cycle pulse
  typedef struct packed {
    logic start;
    logic done;
    logic fail;
  } seq_evt_t;

  // ----------------------------------------------------------------
  // Sequencer tracking states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_BUSY = 2'b01,
    ST_STUCK = 2'b10
  } seq_state_t;

endpackage

// >>> ready_tracker.sv
/*
  Follows the flash sequencer through ready, busy and stuck.
  Assumes one-cycle event pulses on the same clock as the bank.
*/
module ready_tracker (
  input wire logic mclk,
  input wire logic reset,
  input wire flash_csr_pkg::seq_evt_t evt,
  input wire logic reset_cmd,
  output logic ready,
  output logic busy
);

  flash_csr_pkg::seq_state_t state_reg; // Current phase

  // ----------------------------------------------------------------
  // Phase register
  // ----------------------------------------------------------------
  // Reset lands in ready so the flag reads 1 at power on
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg <= flash_csr_pkg::ST_READY;
    end else begin
      unique case (state_reg)
        flash_csr_pkg::ST_READY: begin
          if (evt.start) begin
            state_reg <= flash_csr_pkg::ST_BUSY;
          end
        end
        flash_csr_pkg::ST_BUSY: begin
          if (evt.fail) begin
            state_reg <= flash_csr_pkg::ST_STUCK;
          end else if (evt.done) begin
            state_reg <= flash_csr_pkg::ST_READY;
          end
        end
        flash_csr_pkg::ST_STUCK: begin
          // Only a reset command frees a failed sequencer
          if (reset_cmd) begin
            state_reg <= flash_csr_pkg::ST_READY;
          end
        end
        default: begin
          state_reg <= flash_csr_pkg::ST_READY; // Illegal code
        end
      endcase
    end
  end

  // Ready only in the ready phase; stuck keeps it low
  assign ready = (state_reg == flash_csr_pkg::ST_READY);
  assign busy = (state_reg == flash_csr_pkg::ST_BUSY);

endmodule

// >>> flash_ctrl_status_tb.sv
/*
  Self-checking bench for the flash control and status register bank.
  Assumes the design files and the shared header are compiled first.
*/
`include "flash_csr_cfg.svh"

module flash_ctrl_status_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------
  localparam logic [2:0] GO = 3'h4; // Start pulse
  localparam logic [2:0] OK = 3'h2; // Done pulse
  localparam logic [2:0] NG = 3'h1; // Fail pulse
  logic mclk = 1'b0; // 100 MHz clock
  logic reset = 1'b1; // Held high at start
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  flash_csr_pkg::seq_evt_t seq_evt = '0;
  logic [3:0] area_protect = 4'h0;
  logic mask_rom_strap = 1'b0;
  flash_csr_pkg::cmd_req_t cmd = '0;
  flash_csr_pkg::cmd_req_t cmd_fwd;
  logic cmd_refuse;
  logic cmd_issue_flag;
  logic irq;
  int miscompares = 0; // Mismatch count
  int cmp_count = 0; // Comparison count
  logic [31:0] rd; // Last read word
  logic err; // Last slave error

  // Free-running clock
  always #5 mclk = ~mclk;

  flash_ctrl_status u_flash_ctrl_status (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .seq_evt(seq_evt),
    .area_protect(area_protect), .mask_rom_strap(mask_rom_strap),
    .cmd(cmd), .cmd_fwd(cmd_fwd), .cmd_refuse(cmd_refuse),
    .cmd_issue_flag(cmd_issue_flag), .irq(irq)
  );

  // ----------------------------------------------------------------
  // Compare and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  // One APB transfer; waits for pready, bounded so a hang is seen
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("BAD %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare a word; no slave error expected
  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk_word(rd, exp, "read data");
    chk_bit(err, 1'b0, "read error");
  endtask

  // One sequencer event pulse
  task automatic pulse(input logic [2:0] e);
    @(posedge mclk);
    seq_evt <= e;
    @(posedge mclk);
    seq_evt <= '0;
  endtask

  // Command strobe, then check forward or refusal one cycle later
  task automatic send_cmd(input logic rs, input logic wr, input logic [1:0] ar, input logic ok);
    flash_csr_pkg::cmd_req_t c;
    c = '{valid: 1'b1, is_reset: rs, is_write: wr, area: ar};
    @(posedge mclk);
    cmd <= c;
    @(posedge mclk);
    cmd <= '0;
    @(posedge mclk);
    chk_word({27'h0, cmd_fwd}, ok ? {27'h0, c} : 32'h0, "forwarded command");
    chk_bit(cmd_refuse, !ok, "refusal");
  endtask

  // Strap is held steady across the release edge
  task automatic do_reset(input logic strap);
    mask_rom_strap <= strap;
    reset <= 1'b1;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Watchdog: whole run is about 230 cycles, limit is 10000
  // ----------------------------------------------------------------
  initial begin
    #100000;
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b0);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000001);
    rd_chk(`CSR_IRQ_STAT_ADDR, 32'h00000000);
    rd_chk(`CSR_IRQ_MASK_ADDR, 32'h00000000);
    chk_bit(cmd_issue_flag, 1'b0, "issue flag");
    $display("test reset values done");
    // Only the issue flag is writable; unmapped place is refused
    apb(1'b1, `CSR_STATUS_ADDR, 32'hFFFFFFFF);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000003);
    chk_bit(cmd_issue_flag, 1'b1, "issue flag set");
    apb(1'b1, `CSR_STATUS_ADDR, 32'h00000000);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000001);
    apb(1'b1, 32'hFFFFE52C, 32'hFFFFFFFF);
    chk_bit(err, 1'b1, "unmapped write error");
    apb(1'b0, 32'hFFFFE52C, 32'h0);
    chk_word(rd, 32'h0, "unmapped read data");
    chk_bit(err, 1'b1, "unmapped read error");
    $display("test access kinds done");
    // Every protect combination shows in bits 7:4
    for (int i = 0; i < 16; i++) begin
      area_protect <= i[3:0];
      rd_chk(`CSR_STATUS_ADDR, {24'h0, i[3:0], 4'h1});
    end
    area_protect <= 4'h0;
    $display("test protect flags done");
    // Busy then successful finish
    pulse(GO);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000000);
    pulse(OK);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000001);
    // Failure sticks until a reset command
    pulse(GO);
    pulse(NG);
    pulse(OK);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000000);
    send_cmd(1'b0, 1'b0, 2'h0, 1'b0);
    send_cmd(1'b1, 1'b0, 2'h0, 1'b1);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000001);
    $display("test ready flag done");
    // Command while busy jams later commands until reset command
    pulse(GO);
    send_cmd(1'b0, 1'b1, 2'h2, 1'b0);
    pulse(OK);
    send_cmd(1'b0, 1'b0, 2'h1, 1'b0);
    send_cmd(1'b1, 1'b0, 2'h3, 1'b1);
    send_cmd(1'b0, 1'b1, 2'h1, 1'b1);
    $display("test collision done");
    // Software checks ready, then raises the issue flag
    rd_chk(`CSR_STATUS_ADDR, 32'h00000001);
    apb(1'b1, `CSR_STATUS_ADDR, 32'h00000002);
    // Write into a protected area refused, others pass
    area_protect <= 4'h2;
    repeat (2) @(posedge mclk);
    send_cmd(1'b0, 1'b1, 2'h1, 1'b0);
    send_cmd(1'b0, 1'b1, 2'h0, 1'b1);
    send_cmd(1'b0, 1'b0, 2'h1, 1'b1);
    // Secure state refuses everything, reset command too
    area_protect <= 4'hF;
    repeat (2) @(posedge mclk);
    send_cmd(1'b1, 1'b0, 2'h0, 1'b0);
    send_cmd(1'b0, 1'b0, 2'h0, 1'b0);
    area_protect <= 4'h0;
    rd_chk(`CSR_STATUS_ADDR, 32'h00000003);
    chk_bit(cmd_issue_flag, 1'b1, "issue flag during commands");
    apb(1'b1, `CSR_STATUS_ADDR, 32'h00000000);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000001);
    chk_bit(cmd_issue_flag, 1'b0, "issue flag after commands");
    $display("test command gate done");
    // Interrupt: raised when unmasked, cleared by writing one
    rd_chk(`CSR_IRQ_STAT_ADDR, 32'h0000000F);
    apb(1'b1, `CSR_IRQ_STAT_ADDR, 32'h0000000F);
    rd_chk(`CSR_IRQ_STAT_ADDR, 32'h00000000);
    apb(1'b1, `CSR_IRQ_MASK_ADDR, 32'h00000001);
    rd_chk(`CSR_IRQ_MASK_ADDR, 32'h00000001);
    pulse(GO);
    pulse(OK);
    repeat (3) @(posedge mclk);
    chk_bit(irq, 1'b1, "irq raised");
    rd_chk(`CSR_IRQ_STAT_ADDR, 32'h00000001);
    apb(1'b1, `CSR_IRQ_STAT_ADDR, 32'h00000001);
    repeat (3) @(posedge mclk);
    chk_bit(irq, 1'b0, "irq cleared");
    // Masked failure event is held but gives no interrupt
    pulse(GO);
    pulse(NG);
    repeat (3) @(posedge mclk);
    chk_bit(irq, 1'b0, "irq masked");
    rd_chk(`CSR_IRQ_STAT_ADDR, 32'h00000002);
    send_cmd(1'b1, 1'b0, 2'h0, 1'b1);
    $display("test interrupt done");
    // Mask ROM strap shows in bit 2 after reset
    do_reset(1'b1);
    rd_chk(`CSR_STATUS_ADDR, 32'h00000005);
    $display("test rom kind done");
    print_verdict();
  end
endmodule
